// *** irq_routing_and_tick_timer.sv ***
// Interrupt routing, priority selection, non-maskable source flags and tick timer
// Notes on behaviour
// - Record non-maskable interrupt source in flag register
// - Watchdog raises non-maskable request to CPU
// - Enable loads reload value, then counts down
// - Zero raises tick exception and sets flag
// - Read-only calibration equals ten millisecond count minus one
// - Tick counts selected oscillator divided by 32
// - Highest priority pending request served first
// - Non-wake peripheral requests go straight to CPU
// - Wake sources pass standby-release logic first
// - Non-wake pin requests bypass standby-release logic
// - Set-pending write acts like source request
// - Disabled pin input reads high
// - Pins 0-5 support five trigger modes
// - Remote receive wakes on rising edge only
// - Serial, sync serial, bus sources fixed numbers
`timescale 1ns/1ps
module irq_routing_and_tick_timer #(
  parameter int unsigned OSC0_HZ = 10_000_000,
  parameter int unsigned OSC1_HZ = 8_000_000
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Interrupt sources
  input  wire logic [5:0]  ext_pin_irq_i,
  input  wire logic [19:0] periph_irq_i,
  input  wire logic        watchdog_unit_nmi_i,
  // Oscillator clocks, sampled
  input  wire logic        osc0_i,
  input  wire logic        osc1_i,
  // Towards the CPU core
  output logic [19:0]      cpu_irq_line_o,
  output logic             irq_req_o,
  output logic [4:0]       irq_num_o,
  output logic             nmi_req_o,
  output logic             tick_exception_o,
  output logic             standby_release_o
);

  localparam int unsigned CALIB0 = OSC0_HZ / irq_tick_pkg::TICK_DIV / 1000 * irq_tick_pkg::CALIB_PERIOD_MS - 1;
  localparam int unsigned CALIB1 = OSC1_HZ / irq_tick_pkg::TICK_DIV / 1000 * irq_tick_pkg::CALIB_PERIOD_MS - 1;

  // Elaboration check: calibration must fit and oscillators stay samplable
  if (CALIB0 >= (1 << irq_tick_pkg::TICK_W) || CALIB1 >= (1 << irq_tick_pkg::TICK_W) ||
      OSC0_HZ > 9_000_000 || OSC1_HZ > 9_000_000 || OSC0_HZ < 3_200 || OSC1_HZ < 3_200) begin : g_bad_osc
    $error("oscillator frequency out of range");
  end

  // ==========================================================================
  // Reset release and input synchronisers
  logic [1:0]  rst_sync;
  logic        rst_n;
  logic [5:0]  pin_s1, pin_s2;
  logic [1:0]  osc_s1, osc_s2;
  logic        wdg_s1, wdg_s2;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Two flip-flops on every pin-level input
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 6'h00;
      pin_s2 <= 6'h00;
      osc_s1 <= 2'h0;
      osc_s2 <= 2'h0;
      wdg_s1 <= 1'b0;
      wdg_s2 <= 1'b0;
    end else begin
      pin_s1 <= ext_pin_irq_i;
      pin_s2 <= pin_s1;
      osc_s1 <= {osc1_i, osc0_i};
      osc_s2 <= osc_s1;
      wdg_s1 <= watchdog_unit_nmi_i;
      wdg_s2 <= wdg_s1;
    end
  end

  // ==========================================================================
  // Register storage
  logic [19:0] route_select;
  logic [11:0] wake_irq_mode_ctrl_a;
  logic [5:0]  wake_irq_mode_ctrl_b;
  logic [1:0]  wake_irq_mode_ctrl_e;
  logic [5:0]  port_input_enable;
  logic [19:0] irq_enable;
  logic [19:0] pending;
  logic [95:0] priority_regs;
  logic [0:0]  nmi_source_flags;
  logic [1:0]  tick_ctrl;
  logic        tick_flag;
  logic [23:0] tick_reload;
  logic [23:0] tick_count;
  logic        oscillator_control;

  // Bus decode
  logic        bus_req;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] wmask;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en   = bus_req & wb_we_i;
  assign rd_en   = bus_req & ~wb_we_i;
  assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old_val, input logic [31:0] new_val,
                                        input logic [31:0] mask);
    merge = (old_val & ~mask) | (new_val & mask);
  endfunction : merge

  function automatic logic wr_hit(input logic [7:0] ofs, input logic en, input logic [7:0] adr);
    wr_hit = en && (adr == ofs);
  endfunction : wr_hit

  // Plain read-write configuration registers
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      route_select         <= irq_tick_pkg::RESET_ZERO[19:0];
      wake_irq_mode_ctrl_a <= irq_tick_pkg::RESET_ZERO[11:0];
      wake_irq_mode_ctrl_b <= irq_tick_pkg::RESET_ZERO[5:0];
      wake_irq_mode_ctrl_e <= irq_tick_pkg::RESET_ZERO[1:0];
      port_input_enable    <= irq_tick_pkg::PORT_IN_EN_RST;
      irq_enable           <= irq_tick_pkg::RESET_ZERO[19:0];
      priority_regs        <= {3{irq_tick_pkg::RESET_ZERO}};
      oscillator_control   <= 1'b0;
      tick_reload          <= irq_tick_pkg::RESET_ZERO[23:0];
    end else begin
      if (wr_hit(irq_tick_pkg::OFS_ROUTE_SELECT, wr_en, wb_adr_i))
        route_select <= 20'(merge({12'h000, route_select}, wb_dat_i, wmask)) & irq_tick_pkg::WAKE_CAPABLE;
      if (wr_hit(irq_tick_pkg::OFS_MODE_A, wr_en, wb_adr_i))
        wake_irq_mode_ctrl_a <= 12'(merge({20'h00000, wake_irq_mode_ctrl_a}, wb_dat_i, wmask));
      if (wr_hit(irq_tick_pkg::OFS_MODE_B, wr_en, wb_adr_i))
        wake_irq_mode_ctrl_b <= 6'(merge({26'h0000000, wake_irq_mode_ctrl_b}, wb_dat_i, wmask));
      if (wr_hit(irq_tick_pkg::OFS_MODE_E, wr_en, wb_adr_i))
        wake_irq_mode_ctrl_e <= 2'(merge({30'h00000000, wake_irq_mode_ctrl_e}, wb_dat_i, wmask));
      if (wr_hit(irq_tick_pkg::OFS_PORT_IN_EN, wr_en, wb_adr_i))
        port_input_enable <= 6'(merge({26'h0000000, port_input_enable}, wb_dat_i, wmask));
      if (wr_hit(irq_tick_pkg::OFS_IRQ_ENABLE, wr_en, wb_adr_i))
        irq_enable <= 20'(merge({12'h000, irq_enable}, wb_dat_i, wmask));
      if (wr_hit(irq_tick_pkg::OFS_PRIORITY0, wr_en, wb_adr_i))
        priority_regs[31:0] <= merge(priority_regs[31:0], wb_dat_i, wmask);
      if (wr_hit(irq_tick_pkg::OFS_PRIORITY1, wr_en, wb_adr_i))
        priority_regs[63:32] <= merge(priority_regs[63:32], wb_dat_i, wmask);
      if (wr_hit(irq_tick_pkg::OFS_PRIORITY2, wr_en, wb_adr_i))
        priority_regs[95:64] <= merge(priority_regs[95:64], wb_dat_i, wmask);
      if (wr_hit(irq_tick_pkg::OFS_OSC_CTRL, wr_en, wb_adr_i) && wb_sel_i[0])
        oscillator_control <= wb_dat_i[irq_tick_pkg::OSC_SEL_BIT];
      if (wr_hit(irq_tick_pkg::OFS_TICK_RELOAD, wr_en, wb_adr_i))
        tick_reload <= 24'(merge({8'h00, tick_reload}, wb_dat_i, wmask));
    end
  end

  // ==========================================================================
  // Source conditioning and routing
  logic [5:0]  pin_level;
  logic [19:0] wake_hit;
  logic [19:0] raw_req;

  assign pin_level = pin_s2 | ~port_input_enable;

  // One trigger detector per wake-capable source
  genvar gi;
  generate
    for (gi = 0; gi < irq_tick_pkg::NUM_SRC; gi++) begin : g_src
      if (irq_tick_pkg::WAKE_CAPABLE[gi]) begin : g_wake
        wake_detect_if det_if ();
        if (gi < irq_tick_pkg::NUM_PINS) begin : g_pin
          assign det_if.level = pin_level[gi];
          if (gi < 4) begin : g_a
            assign det_if.mode = wake_irq_mode_ctrl_a[gi*3 +: 3];
          end else begin : g_b
            assign det_if.mode = wake_irq_mode_ctrl_b[(gi-4)*3 +: 3];
          end
        end else begin : g_periph
          assign det_if.level = periph_irq_i[gi];
          if (gi == irq_tick_pkg::SRC_REMOTE_RX) begin : g_rmc
            assign det_if.mode = wake_irq_mode_ctrl_e[1] ? 3'(irq_tick_pkg::MODE_RISE) : 3'h7;
          end else begin : g_cal
            assign det_if.mode = wake_irq_mode_ctrl_e[0] ? 3'(irq_tick_pkg::MODE_FALL) : 3'h7;
          end
        end
        wake_trigger u_trig (
          .clk_i   (ref_clk_i),
          .rst_n_i (rst_n),
          .port_io (det_if)
        );
        assign wake_hit[gi] = det_if.hit;
      end else begin : g_plain
        assign wake_hit[gi] = 1'b0;
      end
    end
  endgenerate

  // Direct or standby-release path per source
  always_comb begin
    raw_req = periph_irq_i;
    raw_req[5:0] = pin_level;
    raw_req = (raw_req & ~route_select) | (wake_hit & route_select);
  end

  assign standby_release_o = |(wake_hit & route_select);

  // CPU interrupt lines mirror the routed requests
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cpu_irq_line_o <= irq_tick_pkg::RESET_ZERO[19:0];
    end else begin
      cpu_irq_line_o <= raw_req;
    end
  end

  // ==========================================================================
  // Pending state: source or set-pending write sets, set wins over clear
  logic [19:0] set_vec, clr_vec;

  assign set_vec = raw_req |
                   (wr_hit(irq_tick_pkg::OFS_SET_PENDING, wr_en, wb_adr_i) ? (wb_dat_i[19:0] & wmask[19:0]) : 20'h00000);
  assign clr_vec = wr_hit(irq_tick_pkg::OFS_CLR_PENDING, wr_en, wb_adr_i) ? (wb_dat_i[19:0] & wmask[19:0]) : 20'h00000;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pending <= irq_tick_pkg::RESET_ZERO[19:0];
    end else begin
      pending <= (pending & ~clr_vec) | set_vec;
    end
  end

  // Priority choice: lowest priority value wins, lower number breaks ties
  logic [3:0]  best_pri;
  logic [4:0]  best_num;
  logic        best_ok;

  always_comb begin
    best_pri = 4'hf;
    best_num = 5'h00;
    best_ok  = 1'b0;
    for (int i = 0; i < irq_tick_pkg::NUM_SRC; i++) begin
      if (pending[i] && irq_enable[i] && (!best_ok || priority_regs[i*4 +: 4] < best_pri)) begin
        best_pri = priority_regs[i*4 +: 4];
        best_num = 5'(i);
        best_ok  = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_req_o <= 1'b0;
      irq_num_o <= 5'h00;
    end else begin
      irq_req_o <= best_ok;
      irq_num_o <= best_num;
    end
  end

  // ==========================================================================
  // Non-maskable source flags
  logic wdg_last;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wdg_last         <= 1'b0;
      nmi_source_flags <= 1'b0;
    end else begin
      wdg_last <= wdg_s2;
      if (wdg_s2 && !wdg_last)
        nmi_source_flags[irq_tick_pkg::NMI_WATCHDOG_BIT] <= 1'b1;
      else if (wr_hit(irq_tick_pkg::OFS_NMI_FLAGS, wr_en, wb_adr_i) && wb_sel_i[0] &&
               wb_dat_i[irq_tick_pkg::NMI_WATCHDOG_BIT])
        nmi_source_flags[irq_tick_pkg::NMI_WATCHDOG_BIT] <= 1'b0;
    end
  end

  assign nmi_req_o = nmi_source_flags[irq_tick_pkg::NMI_WATCHDOG_BIT];

  // ==========================================================================
  // Tick timer: count clock is selected oscillator divided by 32
  logic        osc_sel_s;
  logic        osc_last;
  logic [4:0]  div_cnt;
  logic        count_tick;
  logic        tick_load;

  assign osc_sel_s  = oscillator_control ? osc_s2[1] : osc_s2[0];
  assign count_tick = osc_sel_s && !osc_last && (div_cnt == 5'(irq_tick_pkg::TICK_DIV - 1));

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      osc_last <= 1'b0;
      div_cnt  <= 5'h00;
    end else begin
      osc_last <= osc_sel_s;
      if (osc_sel_s && !osc_last)
        div_cnt <= div_cnt + 5'h01;
    end
  end

  // Control: enable and interrupt enable; enable rising forces a load
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_ctrl <= 2'h0;
    end else if (wr_hit(irq_tick_pkg::OFS_TICK_CTRL, wr_en, wb_adr_i) && wb_sel_i[0]) begin
      tick_ctrl <= wb_dat_i[1:0];
    end
  end

  assign tick_load = (wr_hit(irq_tick_pkg::OFS_TICK_CTRL, wr_en, wb_adr_i) && wb_sel_i[0] &&
                      wb_dat_i[irq_tick_pkg::TICK_EN_BIT] && !tick_ctrl[irq_tick_pkg::TICK_EN_BIT]) ||
                     wr_hit(irq_tick_pkg::OFS_TICK_CURRENT, wr_en, wb_adr_i);

  // Counter: load on enable, count down, reload after zero
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_count <= irq_tick_pkg::RESET_ZERO[23:0];
    end else if (tick_load) begin
      tick_count <= tick_reload;
    end else if (tick_ctrl[irq_tick_pkg::TICK_EN_BIT] && count_tick) begin
      if (tick_count == 24'h000000)
        tick_count <= tick_reload;
      else
        tick_count <= tick_count - 24'h000001;
    end
  end

  // Expiry: flag set wins over clear on read, exception pulse when enabled
  logic tick_expire;

  assign tick_expire = tick_ctrl[irq_tick_pkg::TICK_EN_BIT] && count_tick && !tick_load &&
                       (tick_count == 24'h000001);

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_flag        <= 1'b0;
      tick_exception_o <= 1'b0;
    end else begin
      if (tick_expire)
        tick_flag <= 1'b1;
      else if (wr_hit(irq_tick_pkg::OFS_TICK_CTRL, rd_en, wb_adr_i))
        tick_flag <= 1'b0;
      tick_exception_o <= tick_expire && tick_ctrl[irq_tick_pkg::TICK_INT_BIT];
    end
  end

  // ==========================================================================
  // Wishbone read data and acknowledge, one wait state
  logic [31:0] rd_mux;

  always_comb begin
    unique case (wb_adr_i)
      irq_tick_pkg::OFS_ROUTE_SELECT: rd_mux = {12'h000, route_select};
      irq_tick_pkg::OFS_MODE_A:       rd_mux = {20'h00000, wake_irq_mode_ctrl_a};
      irq_tick_pkg::OFS_MODE_B:       rd_mux = {26'h0000000, wake_irq_mode_ctrl_b};
      irq_tick_pkg::OFS_MODE_E:       rd_mux = {30'h00000000, wake_irq_mode_ctrl_e};
      irq_tick_pkg::OFS_PORT_IN_EN:   rd_mux = {26'h0000000, port_input_enable};
      irq_tick_pkg::OFS_SET_PENDING:  rd_mux = {12'h000, pending};
      irq_tick_pkg::OFS_CLR_PENDING:  rd_mux = {12'h000, pending};
      irq_tick_pkg::OFS_IRQ_ENABLE:   rd_mux = {12'h000, irq_enable};
      irq_tick_pkg::OFS_PRIORITY0:    rd_mux = priority_regs[31:0];
      irq_tick_pkg::OFS_PRIORITY1:    rd_mux = priority_regs[63:32];
      irq_tick_pkg::OFS_PRIORITY2:    rd_mux = priority_regs[95:64];
      irq_tick_pkg::OFS_ACTIVE:       rd_mux = {26'h0000000, best_ok, best_num};
      irq_tick_pkg::OFS_NMI_FLAGS:    rd_mux = {31'h00000000, nmi_source_flags};
      irq_tick_pkg::OFS_TICK_CTRL:    rd_mux = {15'h0000, tick_flag, 14'h0000, tick_ctrl};
      irq_tick_pkg::OFS_TICK_RELOAD:  rd_mux = {8'h00, tick_reload};
      irq_tick_pkg::OFS_TICK_CURRENT: rd_mux = {8'h00, tick_count};
      irq_tick_pkg::OFS_TICK_CALIB:   rd_mux = oscillator_control ? 32'(CALIB1) : 32'(CALIB0);
      irq_tick_pkg::OFS_OSC_CTRL:     rd_mux = {31'h00000000, oscillator_control};
      default:                        rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= rd_en ? rd_mux : 32'h0000_0000;
    end
  end

endmodule : irq_routing_and_tick_timer

// *** irq_tick_pkg.sv ***
// Constants and types shared by the interrupt routing and tick timer design
package irq_tick_pkg;

  // ==========================================================================
  // Source numbering
  localparam int unsigned NUM_SRC          = 20;
  localparam int unsigned NUM_PINS         = 6;
  localparam int unsigned SRC_SERIAL0_RX   = 6;
  localparam int unsigned SRC_SERIAL0_TX   = 7;
  localparam int unsigned SRC_SERIAL1_RX   = 8;
  localparam int unsigned SRC_SERIAL1_TX   = 9;
  localparam int unsigned SRC_SYNC_SERIAL0 = 10;
  localparam int unsigned SRC_SERIAL_BUS0  = 14;
  localparam int unsigned SRC_CALENDAR     = 17;
  localparam int unsigned SRC_REMOTE_RX    = 19;
  // Sources that may be routed through the standby-release logic
  localparam logic [19:0] WAKE_CAPABLE     = 20'ha003f;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_ROUTE_SELECT  = 8'h00;
  localparam logic [7:0] OFS_MODE_A        = 8'h04;
  localparam logic [7:0] OFS_MODE_B        = 8'h08;
  localparam logic [7:0] OFS_MODE_E        = 8'h0c;
  localparam logic [7:0] OFS_PORT_IN_EN    = 8'h10;
  localparam logic [7:0] OFS_SET_PENDING   = 8'h14;
  localparam logic [7:0] OFS_CLR_PENDING   = 8'h18;
  localparam logic [7:0] OFS_IRQ_ENABLE    = 8'h1c;
  localparam logic [7:0] OFS_PRIORITY0     = 8'h20;
  localparam logic [7:0] OFS_PRIORITY1     = 8'h24;
  localparam logic [7:0] OFS_PRIORITY2     = 8'h28;
  localparam logic [7:0] OFS_ACTIVE        = 8'h2c;
  localparam logic [7:0] OFS_NMI_FLAGS     = 8'h30;
  localparam logic [7:0] OFS_TICK_CTRL     = 8'h34;
  localparam logic [7:0] OFS_TICK_RELOAD   = 8'h38;
  localparam logic [7:0] OFS_TICK_CURRENT  = 8'h3c;
  localparam logic [7:0] OFS_TICK_CALIB    = 8'h40;
  localparam logic [7:0] OFS_OSC_CTRL      = 8'h44;

  // ==========================================================================
  // Field positions and reset values
  localparam int unsigned TICK_EN_BIT      = 0;
  localparam int unsigned TICK_INT_BIT     = 1;
  localparam int unsigned TICK_FLAG_BIT    = 16;
  localparam int unsigned NMI_WATCHDOG_BIT = 0;
  localparam int unsigned OSC_SEL_BIT      = 0;
  localparam int unsigned PRI_W            = 4;
  localparam int unsigned MODE_W           = 3;
  localparam logic [31:0] RESET_ZERO       = 32'h0000_0000;
  localparam logic [5:0]  PORT_IN_EN_RST   = 6'h00;

  // ==========================================================================
  // Tick timing
  localparam int unsigned TICK_DIV         = 32;
  localparam int unsigned CALIB_PERIOD_MS  = 10;
  localparam int unsigned TICK_W           = 24;

  // Standby-release trigger modes
  typedef enum logic [2:0] {
    MODE_LOW,
    MODE_HIGH,
    MODE_RISE,
    MODE_FALL,
    MODE_BOTH
  } wake_mode_t;

endpackage : irq_tick_pkg

// *** wake_detect_if.sv ***
// Signals between the router and one standby-release trigger detector
`timescale 1ns/1ps
interface wake_detect_if;
  logic [2:0] mode;   // Trigger mode code
  logic       level;  // Sampled request level
  logic       hit;    // Trigger seen

  modport router (output mode, output level, input hit);
  modport detect (input mode, input level, output hit);
endinterface : wake_detect_if

// *** wake_trigger.sv ***
// One standby-release trigger detector with selectable level or edge mode
`timescale 1ns/1ps
module wake_trigger (
  // Clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  // Router side
  wake_detect_if.detect port_io
);

  logic last_level;

  // ==========================================================================
  // Previous level for edge detection
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_level <= 1'b0;
    end else begin
      last_level <= port_io.level;
    end
  end

  // Mode decode; unused codes never trigger
  always_comb begin
    unique case (port_io.mode)
      irq_tick_pkg::MODE_LOW:  port_io.hit = ~port_io.level;
      irq_tick_pkg::MODE_HIGH: port_io.hit = port_io.level;
      irq_tick_pkg::MODE_RISE: port_io.hit = port_io.level & ~last_level;
      irq_tick_pkg::MODE_FALL: port_io.hit = ~port_io.level & last_level;
      irq_tick_pkg::MODE_BOTH: port_io.hit = port_io.level ^ last_level;
      default:                 port_io.hit = 1'b0;
    endcase
  end

endmodule : wake_trigger

// *** irq_tick_properties.sv ***
// Port checks for the interrupt router and tick timer
`timescale 1ns/1ps
module irq_tick_properties (
  // Clock, reset and bus
  input wire logic        ref_clk_i,
  input wire logic        reset_n_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Requests and results
  input wire logic [19:0] periph_irq_i,
  input wire logic        watchdog_unit_nmi_i,
  input wire logic [19:0] cpu_irq_line_o,
  input wire logic        nmi_req_o,
  input wire logic        tick_exception_o
);
  // ====================
  // Checks on the bus clock
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not after one wait state");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_direct_serial: assert property ($rose(periph_irq_i[7]) |=> cpu_irq_line_o[7])
    else $error("serial request not passed on");
  a_direct_bus: assert property ($rose(periph_irq_i[14]) |=> cpu_irq_line_o[14])
    else $error("bus request not on its line");
  a_nmi_raise: assert property ($rose(watchdog_unit_nmi_i) |-> ##[1:5] nmi_req_o)
    else $error("watchdog nmi missing");
  a_nmi_clear: assert property ($fell(nmi_req_o) |-> wb_we_i && wb_adr_i == 8'h30)
    else $error("nmi flag lost without clear");
  a_tick_pulse: assert property (tick_exception_o |=> !tick_exception_o [*8])
    else $error("tick exception not a single pulse");
endmodule : irq_tick_properties

// *** irq_tick_partner.sv ***
// Oscillator sources feeding the tick timer
`timescale 1ns/1ps
module irq_tick_partner #(
  parameter real HALF0 = 156.25,
  parameter real HALF1 = 78.125
) (
  // Oscillator clocks
  output logic osc0_o,
  output logic osc1_o
);
  // Free running, unrelated in phase to the bus clock
  initial begin
    osc0_o = 1'b0;
    osc1_o = 1'b0;
  end
  always #(HALF0) osc0_o = ~osc0_o;
  always #(HALF1) osc1_o = ~osc1_o;
endmodule : irq_tick_partner

// *** test_irq_routing_and_tick_timer.sv ***
// Bus-driven tests of the interrupt router and tick timer
`timescale 1ns/1ps
module test_irq_routing_and_tick_timer;
  // Stimulus and observed signals
  logic        ref_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [5:0]  pins = 6'h00;
  logic [19:0] periph = 20'h0;
  logic        wdog = 1'b0;
  logic [31:0] rdat;
  logic [19:0] lines;
  logic [4:0]  irq_num;
  logic        ack, osc0, osc1, irq_req, nmi_req, tick_exc, stby;
  logic [4:0]  s0 = 5'b11001;
  int          fails = 0;
  int          checks_done = 0;
  int          n;
  always #25 ref_clk_i = ~ref_clk_i;
  irq_tick_partner u_irq_tick_partner (.osc0_o(osc0), .osc1_o(osc1));
  irq_routing_and_tick_timer #(.OSC0_HZ(3_200_000), .OSC1_HZ(6_400_000)) u_irq_routing_and_tick_timer (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_pin_irq_i(pins), .periph_irq_i(periph), .watchdog_unit_nmi_i(wdog), .osc0_i(osc0),
    .osc1_i(osc1), .cpu_irq_line_o(lines), .irq_req_o(irq_req), .irq_num_o(irq_num),
    .nmi_req_o(nmi_req), .tick_exception_o(tick_exc), .standby_release_o(stby));
  // Verdict and comparison
  task automatic tally_and_finish;
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bound(input int i, input int lim);
    if (i >= lim) begin
      fails++;
      tally_and_finish();
    end
  endtask : bound
  // One classic Wishbone cycle; data taken at the ack edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge ref_clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk_i);
      if (ack === 1'b1) break;
    end
    bound(i, 20);
    q = rdat;
    cyc <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  task automatic cyc_wait(input int k);
    repeat (k) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask : cyc_wait
  task automatic tick_wait(output int c);
    for (c = 0; c < 2000; c++) begin
      @(negedge ref_clk_i);
      if (tick_exc === 1'b1) break;
    end
    bound(c, 2000);
  endtask : tick_wait
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rd(8'h30, 32'h0);
    rd(8'h80, 32'h0);
    rd(8'h40, 32'd999);
    wr(8'h44, 32'h1);
    rd(8'h40, 32'd1999);
    wr(8'h44, 32'h0);
    chk({26'h0, lines[5:0]}, 32'h3f);
    wr(8'h10, 32'h3f);
    @(posedge ref_clk_i);
    periph <= 20'h047c0;
    cyc_wait(2);
    chk({12'h0, lines & 20'h047c0}, 32'h047c0);
    @(posedge ref_clk_i);
    periph <= 20'h0;
    wr(8'h18, 32'hfffff);
    wr(8'h14, 32'h280);
    wr(8'h1c, 32'h280);
    wr(8'h20, 32'h2000_0000);
    cyc_wait(3);
    chk(32'(irq_req), 32'h1);
    rd(8'h14, 32'h280);
    rd(8'h2c, 32'h29);
    wr(8'h24, 32'h30);
    cyc_wait(3);
    chk(32'(irq_num), 32'd7);
    // Every trigger mode of pin 0 through the standby path
    wr(8'h00, 32'h1);
    for (int m = 0; m < 5; m++) begin
      @(posedge ref_clk_i);
      pins[0] <= s0[m];
      wr(8'h04, 32'(m));
      cyc_wait(4);
      wr(8'h18, 32'h1);
      rd(8'h14, 32'h280);
      @(posedge ref_clk_i);
      pins[0] <= ~s0[m];
      cyc_wait(4);
      rd(8'h14, 32'h281);
      chk(32'(stby), 32'(m < 2));
    end
    wr(8'h00, 32'h80000);
    wr(8'h0c, 32'h2);
    @(posedge ref_clk_i);
    periph[19] <= 1'b1;
    cyc_wait(3);
    wr(8'h18, 32'h80001);
    @(posedge ref_clk_i);
    periph[19] <= 1'b0;
    cyc_wait(3);
    rd(8'h14, 32'h280);
    @(posedge ref_clk_i);
    periph[19] <= 1'b1;
    cyc_wait(3);
    rd(8'h14, 32'h80280);
    // Calendar source through the standby path, falling edge only
    wr(8'h00, 32'h20000);
    wr(8'h0c, 32'h1);
    @(posedge ref_clk_i);
    periph[17] <= 1'b1;
    cyc_wait(3);
    rd(8'h14, 32'h80280);
    @(posedge ref_clk_i);
    periph[17] <= 1'b0;
    cyc_wait(3);
    rd(8'h14, 32'ha0280);
    @(posedge ref_clk_i);
    wdog <= 1'b1;
    cyc_wait(6);
    chk(32'(nmi_req), 32'h1);
    rd(8'h30, 32'h1);
    wr(8'h30, 32'h1);
    cyc_wait(2);
    chk(32'(nmi_req), 32'h0);
    // Tick: reload 2 gives three counts of 32 oscillator edges
    wr(8'h38, 32'h2);
    wr(8'h34, 32'h3);
    tick_wait(n);
    tick_wait(n);
    chk(32'(n >= 590 && n <= 610), 32'h1);
    rd(8'h34, 32'h10003);
    rd(8'h34, 32'h3);
    tally_and_finish();
  end
endmodule : test_irq_routing_and_tick_timer
bind irq_routing_and_tick_timer irq_tick_properties u_irq_tick_properties (.ref_clk_i(ref_clk_i),
  .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .periph_irq_i(periph_irq_i),
  .watchdog_unit_nmi_i(watchdog_unit_nmi_i), .cpu_irq_line_o(cpu_irq_line_o),
  .nmi_req_o(nmi_req_o), .tick_exception_o(tick_exception_o));
